// ### hdl/tas_pkg.sv
// Purpose: Shared constants for the temperature alarm status flag block.
// Assumes: One 100 MHz clock, synchronous active-low reset.
// Notes: Register indices are chosen locally; no offsets are printed for them.
package tas_pkg;
   // Register indices on the internal status read port.
   localparam logic [7:0] REG_OVERTEMP_STATUS = 8'h01;
   localparam logic [7:0] REG_DIODE_FAULT_STATUS = 8'h02;
   // Reset values of both status registers.
   localparam logic [7:0] OVERTEMP_STATUS_RST = 8'h00;
   localparam logic [7:0] DIODE_FAULT_STATUS_RST = 8'h00;
   // Overtemperature status bit positions.
   localparam int OT_BIT_CH1 = 0;
   localparam int OT_BIT_CH4 = 3;
   localparam int OT_BIT_CH5 = 4;
   localparam int OT_BIT_CH6 = 5;
   // Diode fault bits sit at the channel number, channel 1 at bit 1.
   localparam int DF_BIT_BASE = 1;
   localparam int NUM_CH = 6;
   // Bits of the overtemperature register that can ever be set.
   localparam logic [7:0] OT_USED_MASK = 8'h39;
   // Bits of the diode fault register that can ever be set.
   localparam logic [7:0] DF_USED_MASK = 8'h7e;
   // Default bus slave address of one variant; other variants are set by parameter.
   localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h1a;
endpackage : tas_pkg

// ### hdl/tas_sync.sv
// Purpose: Three-flop synchroniser for one pin level per bit.
// Assumes: Pins change slowly compared with the clock.
// Notes: A change is accepted once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module tas_sync #(
   parameter int WIDTH = 6
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_nrst,
   // Raw and filtered levels.
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;

   // Each bit has its own three-stage chain and agreement filter.
   genvar g;
   for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge i_clk) begin
         if (!i_nrst) begin
            s1_r[g] <= 1'b0;
            s2_r[g] <= 1'b0;
            s3_r[g] <= 1'b0;
            o_sync[g] <= 1'b0;
         end else begin
            s1_r[g] <= i_async[g];
            s2_r[g] <= s1_r[g];
            s3_r[g] <= s2_r[g];
            if (s2_r[g] == s3_r[g]) begin
               o_sync[g] <= s3_r[g];
            end
         end
      end
   end
endmodule : tas_sync
`default_nettype wire

// ### hdl/tas_status.sv
// Purpose: Overtemperature and diode fault status flags of a six-channel monitor.
// Assumes: Conversion results and limits come from logic on the same clock.
// Notes: Diode fault pins are asynchronous and are synchronised here.
// What this block does
// - Channel 6 above its overtemperature limit sets overtemp status bit 5.
// - Channel 5 above its overtemperature limit sets overtemp status bit 4.
// - Channel 4 above its overtemperature limit sets overtemp status bit 3.
// - Channel 1 above its overtemperature limit sets overtemp status bit 0.
// - Channel 6 open or anode at supply sets diode fault bit 6.
// - Channels 2 to 5 faulted set diode fault bits 2 to 5.
// - Channel 1 open or anode at supply sets diode fault bit 1.
// - Device acknowledges only its one fixed 7-bit variant slave address; reads return data at any address.
// - Channels with a diode fault are skipped in the measurement sequence.
// - A set overtemperature mask bit suppresses that channel's overtemp output.
`timescale 1ns/1ps
`default_nettype none
module tas_status #(
   parameter logic [6:0] SLAVE_ADDR = tas_pkg::SLAVE_ADDR_DEFAULT,
   parameter int NCH = tas_pkg::NUM_CH
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_nrst,
   // Conversion results, one channel per cycle of i_conv_valid.
   input wire logic i_conv_valid,
   input wire logic [2:0] i_conv_ch,
   input wire logic [7:0] i_conv_temp,
   input wire logic [7:0] i_ot_limit_ch1,
   input wire logic [7:0] i_ot_limit_ch4,
   input wire logic [7:0] i_ot_limit_ch5,
   input wire logic [7:0] i_ot_limit_ch6,
   // Overtemperature mask bits, index = channel number.
   input wire logic [6:0] i_ot_mask,
   // Diode fault detector levels per channel 1..6 from the analog front end.
   input wire logic [NCH-1:0] i_diode_fault,
   // Register read port from the serial interface.
   input wire logic i_addr_valid,
   input wire logic [6:0] i_addr,
   input wire logic i_rd,
   input wire logic [7:0] i_reg_idx,
   output logic o_addr_ack,
   output logic [7:0] o_rd_data,
   // Sequencer and open-drain overtemperature output.
   output logic [NCH-1:0] o_ch_enable,
   output logic o_overtemp_output_oe
);
   logic [7:0] overtemp_status_r;
   logic [7:0] diode_fault_status_r;
   logic [NCH-1:0] fault_sync;
   logic [7:0] ot_hit;

   // Diode fault pins enter through the three-flop synchroniser.
   tas_sync #(.WIDTH(NCH)) u_sync (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_async(i_diode_fault),
      .o_sync(fault_sync)
   );

   // Compare the result against the limit of the channel just converted.
   always_comb begin
      ot_hit = 8'h00;
      if (i_conv_valid) begin
         unique case (i_conv_ch)
            3'h1: ot_hit[tas_pkg::OT_BIT_CH1] = i_conv_temp > i_ot_limit_ch1;
            3'h4: ot_hit[tas_pkg::OT_BIT_CH4] = i_conv_temp > i_ot_limit_ch4;
            3'h5: ot_hit[tas_pkg::OT_BIT_CH5] = i_conv_temp > i_ot_limit_ch5;
            3'h6: ot_hit[tas_pkg::OT_BIT_CH6] = i_conv_temp > i_ot_limit_ch6;
            default: ot_hit = 8'h00;
         endcase
      end
   end

   // Overtemperature flags follow each new conversion of their channel.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         overtemp_status_r <= tas_pkg::OVERTEMP_STATUS_RST;
      end else if (i_conv_valid) begin
         unique case (i_conv_ch)
            3'h1: overtemp_status_r[tas_pkg::OT_BIT_CH1] <= ot_hit[tas_pkg::OT_BIT_CH1];
            3'h4: overtemp_status_r[tas_pkg::OT_BIT_CH4] <= ot_hit[tas_pkg::OT_BIT_CH4];
            3'h5: overtemp_status_r[tas_pkg::OT_BIT_CH5] <= ot_hit[tas_pkg::OT_BIT_CH5];
            3'h6: overtemp_status_r[tas_pkg::OT_BIT_CH6] <= ot_hit[tas_pkg::OT_BIT_CH6];
            default: overtemp_status_r <= overtemp_status_r;
         endcase
      end
   end

   // Diode fault flags track the filtered detectors; bit 0 and bit 7 stay zero.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         diode_fault_status_r <= tas_pkg::DIODE_FAULT_STATUS_RST;
      end else begin
         // Channel n lands at bit n.
         diode_fault_status_r <= {1'b0, fault_sync, 1'b0} & tas_pkg::DF_USED_MASK;
      end
   end

   // Faulted channels drop out of the measurement sequence.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_ch_enable <= '0;
      end else begin
         o_ch_enable <= ~fault_sync;
      end
   end

   // Overtemperature output pulls low while any unmasked flag is set.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_overtemp_output_oe <= 1'b0;
      end else begin
         o_overtemp_output_oe <= |(overtemp_status_r & ~{2'b00, i_ot_mask[6:4],
                                 2'b00, i_ot_mask[1]} & tas_pkg::OT_USED_MASK);
      end
   end

   // Address match for the serial interface.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_addr_ack <= 1'b0;
      end else begin
         o_addr_ack <= i_addr_valid && (i_addr == SLAVE_ADDR);
      end
   end

   // Register read mux; unknown indices and reserved bits read zero.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_rd_data <= 8'h00;
      end else if (i_rd) begin
         if (i_reg_idx == tas_pkg::REG_OVERTEMP_STATUS) begin
            o_rd_data <= overtemp_status_r & tas_pkg::OT_USED_MASK;
         end else if (i_reg_idx == tas_pkg::REG_DIODE_FAULT_STATUS) begin
            o_rd_data <= diode_fault_status_r & tas_pkg::DF_USED_MASK;
         end else begin
            o_rd_data <= 8'h00;
         end
      end
   end

   // Overtemperature flag follows a conversion one edge later.
   property p_ot_ch6;
      @(posedge i_clk) disable iff (!i_nrst)
      (i_conv_valid && i_conv_ch == 3'h6) |=> overtemp_status_r[5] == $past(i_conv_temp > i_ot_limit_ch6);
   endproperty
   AST_OT_CH6: assert property (p_ot_ch6) else $error("ch6 overtemp flag wrong");
   AST_OT_CH5: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_conv_valid && i_conv_ch == 3'h5) |=> overtemp_status_r[4] == $past(i_conv_temp > i_ot_limit_ch5))
      else $error("ch5 overtemp flag wrong");
   AST_OT_CH4: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_conv_valid && i_conv_ch == 3'h4) |=> overtemp_status_r[3] == $past(i_conv_temp > i_ot_limit_ch4))
      else $error("ch4 overtemp flag wrong");
   AST_OT_CH1: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_conv_valid && i_conv_ch == 3'h1) |=> overtemp_status_r[0] == $past(i_conv_temp > i_ot_limit_ch1))
      else $error("ch1 overtemp flag wrong");
   // A steady fault pin reaches its status bit within five edges.
   sequence s_fault6_steady;
      i_diode_fault[5] [*5];
   endsequence
   AST_DF_CH6: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_fault6_steady |=> diode_fault_status_r[6]) else $error("ch6 fault bit not set");
   AST_DF_MID: assert property (@(posedge i_clk) disable iff (!i_nrst)
      $past(i_nrst) |-> diode_fault_status_r[5:2] == $past(fault_sync[4:1]))
      else $error("ch2-5 fault bits wrong");
   AST_DF_CH1: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_diode_fault[0] [*5]) |=> diode_fault_status_r[1]) else $error("ch1 fault bit not set");
   AST_ADDR: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_addr_ack |-> $past(i_addr) == SLAVE_ADDR) else $error("wrong address acknowledged");
   AST_SKIP: assert property (@(posedge i_clk) disable iff (!i_nrst)
      diode_fault_status_r[1] |-> !o_ch_enable[0]) else $error("faulted channel still enabled");
   AST_MASK: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (overtemp_status_r == 8'h01 && $stable(i_ot_mask) && i_ot_mask[1]) |=> !o_overtemp_output_oe)
      else $error("masked channel drove overtemp output");
   AST_RSVD: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (o_rd_data & 8'h80) == 8'h00) else $error("reserved bit read as one");

   // Reserved positions of both status registers never hold a one.
   AST_OT_RSVD: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (overtemp_status_r & ~tas_pkg::OT_USED_MASK) == 8'h00)
      else $error("overtemp reserved bit set");
   AST_DF_RSVD: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (diode_fault_status_r & ~tas_pkg::DF_USED_MASK) == 8'h00)
      else $error("diode fault reserved bit set");

   // A matching address pulse is always acknowledged on the next edge.
   sequence s_own_addr;
      i_addr_valid && (i_addr == SLAVE_ADDR);
   endsequence
   AST_ADDR_MATCH: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_own_addr |=> o_addr_ack) else $error("own address not acknowledged");

   // A read returns the flags held at the edge that took the request.
   sequence s_read_ot;
      i_rd && (i_reg_idx == tas_pkg::REG_OVERTEMP_STATUS);
   endsequence
   sequence s_read_df;
      i_rd && (i_reg_idx == tas_pkg::REG_DIODE_FAULT_STATUS);
   endsequence
   AST_RD_OT: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_read_ot |=> o_rd_data == ($past(overtemp_status_r) & tas_pkg::OT_USED_MASK))
      else $error("overtemp read data wrong");
   AST_RD_DF: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_read_df |=> o_rd_data == ($past(diode_fault_status_r) & tas_pkg::DF_USED_MASK))
      else $error("diode fault read data wrong");

   // Without a conversion the overtemperature flags keep their value.
   AST_OT_HOLD: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ($past(i_nrst) && !$past(i_conv_valid)) |-> $stable(overtemp_status_r))
      else $error("overtemp flags changed without a conversion");

   // With no flag set the overtemperature pin is released on the next edge.
   AST_OE_IDLE: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (overtemp_status_r == 8'h00) |=> !o_overtemp_output_oe)
      else $error("overtemp output driven with no flag set");

   // A healthy channel 6 stays in the measurement sequence.
   AST_EN_CH6: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ($past(i_nrst) && !diode_fault_status_r[6]) |-> o_ch_enable[5])
      else $error("healthy channel dropped from sequence");
endmodule : tas_status
`default_nettype wire

// ### sim/tas_host.sv
// Purpose: Host-side model that presents a slave address and a register read.
// Assumes: The device answers one rising edge after each request.
// Notes: Released address and index lines show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module tas_host (
   // Clock.
   input wire logic i_clk,
   // Answers from the device.
   input wire logic i_ack,
   input wire logic [7:0] i_data,
   // Requests to the device.
   output logic o_addr_valid,
   output logic [6:0] o_addr,
   output logic o_rd,
   output logic [7:0] o_reg_idx
);
   // The bus is idle at time zero.
   initial begin
      o_addr_valid = 1'b0;
      o_addr = 7'h00;
      o_rd = 1'b0;
      o_reg_idx = 8'h00;
   end
   // One address and read cycle; answers are taken when the request is dropped.
   task automatic read(input logic [6:0] adr, input logic [7:0] idx, output logic ack,
                       output logic [7:0] data);
      @(negedge i_clk);
      o_addr_valid = 1'b1;
      o_addr = adr;
      o_rd = 1'b1;
      o_reg_idx = idx;
      @(negedge i_clk);
      ack = i_ack;
      data = i_data;
      o_addr_valid = 1'b0;
      o_rd = 1'b0;
      o_addr = ~adr;
      o_reg_idx = ~idx;
   endtask : read
endmodule : tas_host
`default_nettype wire

// ### sim/temp_alarm_status_flags_test.sv
// Purpose: Self-checking bench for the status flag block.
// Assumes: Default slave address; limits held constant.
// Notes: Ordinary conversions run from a table, odd cases follow by hand.
`timescale 1ns/1ps
`default_nettype none
module temp_alarm_status_flags_test;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic conv_valid = 1'b0;
   logic [2:0] conv_ch = 3'h0;
   logic [7:0] conv_temp = 8'h00;
   logic [6:0] ot_mask = 7'h00;
   logic [5:0] fault = 6'h00;
   logic addr_valid, rd, addr_ack, oe, ack;
   logic [6:0] addr;
   logic [7:0] reg_idx, rd_data, data;
   logic [5:0] ch_enable;
   int bad_count = 0;
   int n_compared = 0;
   // Rows: channel, temperature, overtemp status expected after it.
   localparam logic [18:0] ROWS [10] = '{{3'h1, 8'h51, 8'h01}, {3'h4, 8'h61, 8'h09},
      {3'h5, 8'h71, 8'h19}, {3'h6, 8'h41, 8'h39}, {3'h2, 8'hff, 8'h39}, {3'h1, 8'h50, 8'h38},
      {3'h6, 8'h40, 8'h18}, {3'h7, 8'hff, 8'h18}, {3'h4, 8'h60, 8'h10}, {3'h5, 8'h70, 8'h00}};
   // Free-running 100 MHz clock.
   always #5 i_clk = ~i_clk;
   tas_status i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_conv_valid(conv_valid),
      .i_conv_ch(conv_ch), .i_conv_temp(conv_temp), .i_ot_limit_ch1(8'h50),
      .i_ot_limit_ch4(8'h60), .i_ot_limit_ch5(8'h70), .i_ot_limit_ch6(8'h40),
      .i_ot_mask(ot_mask), .i_diode_fault(fault), .i_addr_valid(addr_valid), .i_addr(addr),
      .i_rd(rd), .i_reg_idx(reg_idx), .o_addr_ack(addr_ack), .o_rd_data(rd_data),
      .o_ch_enable(ch_enable), .o_overtemp_output_oe(oe));
   tas_host i_host (.i_clk(i_clk), .i_ack(addr_ack), .i_data(rd_data), .o_addr_valid(addr_valid),
      .o_addr(addr), .o_rd(rd), .o_reg_idx(reg_idx));
   // Compares one value and counts the outcome.
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // Presents one conversion result for a single cycle.
   task automatic convert(input logic [2:0] ch, input logic [7:0] temp);
      @(negedge i_clk);
      conv_valid = 1'b1;
      conv_ch = ch;
      conv_temp = temp;
      @(negedge i_clk);
      conv_valid = 1'b0;
      conv_temp = ~temp;
   endtask : convert
   // Reads one register at the given address.
   task automatic get(input logic [7:0] idx, input logic [6:0] adr);
      i_host.read(adr, idx, ack, data);
   endtask : get
   // Prints the counts and the verdict, then stops.
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   // Cuts a hang short.
   initial begin
      #20000;
      bad_count++;
      complete_run();
   end
   // Main sequence.
   initial begin
      repeat (4) @(negedge i_clk);
      check("ch_enable in reset", {2'h0, ch_enable}, 8'h00);
      i_nrst = 1'b1;
      get(tas_pkg::REG_OVERTEMP_STATUS, tas_pkg::SLAVE_ADDR_DEFAULT);
      check("overtemp reset", data, 8'h00);
      check("ack", {7'h00, ack}, 8'h01);
      get(tas_pkg::REG_DIODE_FAULT_STATUS, tas_pkg::SLAVE_ADDR_DEFAULT);
      check("fault reset", data, 8'h00);
      for (int i = 0; i < 10; i++) begin
         convert(ROWS[i][18:16], ROWS[i][15:8]);
         get(tas_pkg::REG_OVERTEMP_STATUS, tas_pkg::SLAVE_ADDR_DEFAULT);
         check("overtemp", data, ROWS[i][7:0]);
         @(negedge i_clk);
         check("oe", {7'h00, oe}, {7'h00, |ROWS[i][7:0]});
      end
      get(tas_pkg::REG_OVERTEMP_STATUS, 7'h1c);
      check("foreign ack", {7'h00, ack}, 8'h00);
      get(8'h05, tas_pkg::SLAVE_ADDR_DEFAULT);
      check("unknown index", data, 8'h00);
      ot_mask = 7'h40;
      convert(3'h6, 8'hff);
      get(tas_pkg::REG_OVERTEMP_STATUS, tas_pkg::SLAVE_ADDR_DEFAULT);
      check("masked ch6", data, 8'h20);
      @(negedge i_clk);
      check("masked oe", {7'h00, oe}, 8'h00);
      ot_mask = 7'h02;
      convert(3'h6, 8'h00);
      convert(3'h1, 8'hff);
      get(tas_pkg::REG_OVERTEMP_STATUS, tas_pkg::SLAVE_ADDR_DEFAULT);
      check("masked ch1", data, 8'h01);
      @(negedge i_clk);
      check("masked ch1 oe", {7'h00, oe}, 8'h00);
      for (int i = 0; i < 2; i++) begin
         fault = i == 0 ? 6'h15 : 6'h2a;
         repeat (10) @(negedge i_clk);
         get(tas_pkg::REG_DIODE_FAULT_STATUS, tas_pkg::SLAVE_ADDR_DEFAULT);
         check("fault", data, {1'b0, fault, 1'b0});
         check("ch_enable", {2'h0, ch_enable}, {2'h0, ~fault});
      end
      fault = 6'h00;
      i_nrst = 1'b0;
      @(negedge i_clk);
      i_nrst = 1'b1;
      get(tas_pkg::REG_OVERTEMP_STATUS, tas_pkg::SLAVE_ADDR_DEFAULT);
      check("overtemp after reset", data, 8'h00);
      complete_run();
   end
endmodule : temp_alarm_status_flags_test
`default_nettype wire
